// ### include/fsc_consts.vh
`ifndef FSC_CONSTS_VH
`define FSC_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define FSC_ADDR_CTRL 8'h00
`define FSC_ADDR_TORQUE 8'h04
`define FSC_ADDR_DECEL 8'h08
`define FSC_ADDR_STATUS 8'h0C
`define FSC_ADDR_SPEED 8'h10
`define FSC_ADDR_MAXTRQ 8'h14

// ****************************************************************
// Control register fields
// ****************************************************************
`define FSC_CTRL_METHOD_LSB 0
`define FSC_CTRL_SOFF_DB_BIT 4
`define FSC_CTRL_TRQ_MODE_BIT 5
`define FSC_CTRL_ALLOC_LSB 8
`define FSC_CTRL_MAPPED_BIT 12

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define FSC_METHOD_RST 3'h0
`define FSC_ALLOC_RST 4'h0
`define FSC_TORQUE_RST 10'h0320
`define FSC_TORQUE_MAX 10'h0320
`define FSC_DECEL_RST 14'h0000
`define FSC_DECEL_MAX 14'h2EE0
`define FSC_MAXTRQ_RST 10'h012C

// ****************************************************************
// Timing
// ****************************************************************
`define FSC_CLK_MHZ 250
`define FSC_MS_US 1000
`define FSC_MS_CYCLES (`FSC_CLK_MHZ * `FSC_MS_US)

`endif

// ### verilog/fsc_forced_stop.v
`include "fsc_consts.vh"
`default_nettype none

module fsc_forced_stop (
	input wire clk_i,
	input wire sys_rst_i,
	input wire stop_request_input_i,
	input wire servo_on_i,
	input wire motor_stopped_i,
	input wire [7:0] addr_i,
	input wire [31:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [31:0] rdata_o,
	output reg forced_stop_indication_o,
	output reg dynamic_braking_o,
	output reg power_stage_blocked_o,
	output reg decel_active_o,
	output reg [9:0] torque_limit_o,
	output reg [15:0] speed_ref_o
);

	// ****************************************************************
	// Stopping phases
	// ****************************************************************
	localparam ST_RUN = 2'h0;
	localparam ST_DECEL = 2'h1;
	localparam ST_HOLD = 2'h2;

	localparam [31:0] MS_CYC = `FSC_MS_CYCLES;

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	reg [2:0] method_reg;
	reg soff_db_reg;
	reg trq_mode_reg;
	reg [3:0] alloc_reg;
	reg mapped_reg;
	reg [9:0] torque_reg;
	reg [13:0] decel_reg;
	reg [15:0] speed_in_reg;
	reg [9:0] maxtrq_reg;

	reg sync1_reg;
	reg sync2_reg;
	reg srv1_reg;
	reg srv2_reg;
	reg stop1_reg;
	reg stop2_reg;
	reg [1:0] state_reg;
	reg latch_reg;
	reg [31:0] ms_cnt_reg;
	reg [15:0] speed_reg;
	reg [15:0] step_reg;
	reg [31:0] rdata_next;

	wire alloc_ok = (alloc_reg == 4'h1) || (alloc_reg == 4'h2);
	wire stop_open = alloc_ok && mapped_reg && !sync2_reg;
	wire [9:0] trq_clamped = (torque_reg > maxtrq_reg) ? maxtrq_reg : torque_reg;
	wire use_trq = (method_reg == 3'h1) || (method_reg == 3'h2);
	wire use_time = (method_reg == 3'h3) || (method_reg == 3'h4);
	wire coast_after = (method_reg == 3'h2) || (method_reg == 3'h4);
	wire [15:0] full_speed = 16'hFFFF;
	wire [15:0] ramp_step = (decel_reg == 14'h0000) ? full_speed :
		(full_speed / {2'h0, decel_reg});

	// ****************************************************************
	// Register bus
	// ****************************************************************
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			method_reg <= `FSC_METHOD_RST;
			soff_db_reg <= 1'b1;
			trq_mode_reg <= 1'b0;
			alloc_reg <= `FSC_ALLOC_RST;
			mapped_reg <= 1'b0;
			torque_reg <= `FSC_TORQUE_RST;
			decel_reg <= `FSC_DECEL_RST;
			speed_in_reg <= 16'h0000;
			maxtrq_reg <= `FSC_MAXTRQ_RST;
		end else if (wr_i) begin
			case (addr_i)
				`FSC_ADDR_CTRL: begin
					method_reg <= (wdata_i[2:0] > 3'h4) ? method_reg : wdata_i[2:0];
					soff_db_reg <= wdata_i[`FSC_CTRL_SOFF_DB_BIT];
					trq_mode_reg <= wdata_i[`FSC_CTRL_TRQ_MODE_BIT];
					alloc_reg <= wdata_i[11:8];
					mapped_reg <= wdata_i[`FSC_CTRL_MAPPED_BIT];
				end
				`FSC_ADDR_TORQUE: begin
					torque_reg <= (wdata_i[9:0] > `FSC_TORQUE_MAX) ? `FSC_TORQUE_MAX :
						wdata_i[9:0];
				end
				`FSC_ADDR_DECEL: begin
					decel_reg <= (wdata_i[13:0] > `FSC_DECEL_MAX) ? `FSC_DECEL_MAX :
						wdata_i[13:0];
				end
				`FSC_ADDR_SPEED: begin
					speed_in_reg <= wdata_i[15:0];
				end
				`FSC_ADDR_MAXTRQ: begin
					maxtrq_reg <= wdata_i[9:0];
				end
				default: begin
				end
			endcase
		end
	end

	always @* begin
		rdata_next = 32'h0000_0000;
		if (rd_i) begin
			case (addr_i)
				`FSC_ADDR_CTRL: rdata_next = {19'h0_0000, mapped_reg, alloc_reg, 2'h0,
					trq_mode_reg, soff_db_reg, 1'b0, method_reg};
				`FSC_ADDR_TORQUE: rdata_next = {22'h00_0000, torque_reg};
				`FSC_ADDR_DECEL: rdata_next = {18'h0_0000, decel_reg};
				`FSC_ADDR_STATUS: rdata_next = {28'h000_0000, sync2_reg, state_reg,
					latch_reg};
				`FSC_ADDR_SPEED: rdata_next = {16'h0000, speed_reg};
				`FSC_ADDR_MAXTRQ: rdata_next = {22'h00_0000, maxtrq_reg};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	// two-stage sync
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			srv1_reg <= 1'b0;
			srv2_reg <= 1'b0;
			stop1_reg <= 1'b0;
			stop2_reg <= 1'b0;
		end else begin
			sync1_reg <= stop_request_input_i;
			sync2_reg <= sync1_reg;
			srv1_reg <= servo_on_i;
			srv2_reg <= srv1_reg;
			stop1_reg <= motor_stopped_i;
			stop2_reg <= stop1_reg;
		end
	end

	// ****************************************************************
	// Forced-stop latch and stopping sequence
	// ****************************************************************
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			latch_reg <= 1'b0;
			state_reg <= ST_RUN;
			ms_cnt_reg <= 32'h0000_0000;
			speed_reg <= 16'h0000;
			step_reg <= 16'h0000;
		end else begin
			if (stop_open) begin
				latch_reg <= 1'b1;
			end else if (!srv2_reg) begin
				latch_reg <= 1'b0;
			end
			case (state_reg)
				ST_RUN: begin
					speed_reg <= speed_in_reg;
					ms_cnt_reg <= 32'h0000_0000;
					step_reg <= ramp_step;
					if (stop_open) begin
						if (trq_mode_reg || method_reg == 3'h0) begin
							state_reg <= ST_HOLD;
							speed_reg <= 16'h0000;
						end else if (use_time && decel_reg == 14'h0000) begin
							state_reg <= ST_HOLD;
							speed_reg <= 16'h0000;
						end else begin
							state_reg <= ST_DECEL;
						end
					end
				end
				ST_DECEL: begin
					if (use_trq) begin
						speed_reg <= 16'h0000;
						if (stop2_reg) begin
							state_reg <= ST_HOLD;
						end
					end else begin
						step_reg <= ramp_step;
						if (ms_cnt_reg == MS_CYC - 32'h0000_0001) begin
							ms_cnt_reg <= 32'h0000_0000;
							speed_reg <= (speed_reg > step_reg) ? speed_reg - step_reg :
								16'h0000;
						end else begin
							ms_cnt_reg <= ms_cnt_reg + 32'h0000_0001;
						end
						if (speed_reg == 16'h0000) begin
							state_reg <= ST_HOLD;
						end
					end
				end
				ST_HOLD: begin
					speed_reg <= 16'h0000;
					if (!latch_reg && !stop_open) begin
						state_reg <= ST_RUN;
					end
				end
				default: begin
					state_reg <= ST_RUN;
				end
			endcase
		end
	end

	// ****************************************************************
	// Registered outputs
	// ****************************************************************
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			rdata_o <= 32'h0000_0000;
			forced_stop_indication_o <= 1'b0;
			dynamic_braking_o <= 1'b0;
			power_stage_blocked_o <= 1'b0;
			decel_active_o <= 1'b0;
			torque_limit_o <= 10'h000;
			speed_ref_o <= 16'h0000;
		end else begin
			rdata_o <= rdata_next;
			forced_stop_indication_o <= latch_reg;
			decel_active_o <= (state_reg == ST_DECEL);
			torque_limit_o <= (state_reg == ST_DECEL && use_trq) ? trq_clamped :
				maxtrq_reg;
			speed_ref_o <= speed_reg;
			// Coast or brake once the power stage is blocked in the hold phase
			power_stage_blocked_o <= (state_reg == ST_HOLD) || !srv2_reg;
			dynamic_braking_o <= (state_reg == ST_HOLD) && soff_db_reg &&
				!(coast_after && !trq_mode_reg);
		end
	end

endmodule

`default_nettype wire

// ### testbench/fsc_stop_switch.sv
`default_nettype none
module fsc_stop_switch (
	input wire logic clk_i,
	input wire logic open_i,
	input wire logic wire_break_i,
	input wire logic servo_cmd_i,
	output logic stop_request_input_o,
	output var logic servo_on_o
);
	// ****************
	// Host and switch
	// ****************
	// normally closed contact
	assign stop_request_input_o = !(open_i || wire_break_i);
	always @(posedge clk_i) servo_on_o <= servo_cmd_i;
endmodule
`default_nettype wire

// ### testbench/fsc_forced_stop_props.sv
`include "fsc_consts.vh"
`default_nettype none
module fsc_forced_stop_props (
	input wire clk_i,
	input wire sys_rst_i,
	input wire stop_request_input_i,
	input wire servo_on_i,
	input wire forced_stop_indication_o,
	input wire dynamic_braking_o,
	input wire decel_active_o,
	input wire [9:0] torque_limit_o,
	input wire [15:0] speed_ref_o
);
	// ****************
	// Checks
	// ****************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_lat; $rose(forced_stop_indication_o) |-> !$past(stop_request_input_i, 4); endproperty
	a_lat: assert property (p_lat) else $error("latch without open input");
	property p_run;
		(stop_request_input_i [*5] ##0 !forced_stop_indication_o) |=> !forced_stop_indication_o;
	endproperty
	a_run: assert property (p_run) else $error("stop while input closed");
	property p_hold; (servo_on_i [*4] ##0 forced_stop_indication_o) |=> forced_stop_indication_o;
	endproperty
	a_hold: assert property (p_hold) else $error("latch dropped with servo on");
	property p_clr; $fell(forced_stop_indication_o) |-> !$past(servo_on_i, 4); endproperty
	a_clr: assert property (p_clr) else $error("latch cleared without servo off");
	property p_trq; torque_limit_o <= `FSC_TORQUE_MAX; endproperty
	a_trq: assert property (p_trq) else $error("torque limit above range");
	property p_clamp; $rose(decel_active_o) |-> torque_limit_o <= $past(torque_limit_o); endproperty
	a_clamp: assert property (p_clamp) else $error("stop torque above motor max");
	property p_ramp; decel_active_o && $past(decel_active_o) |-> speed_ref_o <= $past(speed_ref_o);
	endproperty
	a_ramp: assert property (p_ramp) else $error("speed rose while decelerating");
	property p_excl; !(dynamic_braking_o && decel_active_o); endproperty
	a_excl: assert property (p_excl) else $error("brake during deceleration");
endmodule
bind fsc_forced_stop fsc_forced_stop_props u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.stop_request_input_i(stop_request_input_i), .servo_on_i(servo_on_i),
	.forced_stop_indication_o(forced_stop_indication_o), .dynamic_braking_o(dynamic_braking_o),
	.decel_active_o(decel_active_o), .torque_limit_o(torque_limit_o), .speed_ref_o(speed_ref_o));
`default_nettype wire

// ### testbench/fsc_forced_stop_tb.sv
`include "fsc_consts.vh"
`default_nettype none
module fsc_forced_stop_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, sys_rst_i = 1, stopped = 0, wr_i = 0, rd_i = 0;
	logic open_cmd = 0, wire_break = 0, servo_cmd = 1;
	logic [7:0] addr_i = 0;
	logic [31:0] wdata_i = 0;
	wire pin, son, ind, brake, blocked, decel;
	wire [31:0] rdata_o;
	wire [9:0] trq;
	wire [15:0] spd;
	int mismatches = 0, n_compared = 0, cycles = 0;
	// ****************
	// Harness
	// ****************
	always #2 clk_i = ~clk_i;
	fsc_stop_switch u_host (.clk_i(clk_i), .open_i(open_cmd), .wire_break_i(wire_break),
		.servo_cmd_i(servo_cmd), .stop_request_input_o(pin), .servo_on_o(son));
	fsc_forced_stop u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .stop_request_input_i(pin),
		.servo_on_i(son), .motor_stopped_i(stopped), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .forced_stop_indication_o(ind),
		.dynamic_braking_o(brake), .power_stage_blocked_o(blocked), .decel_active_o(decel),
		.torque_limit_o(trq), .speed_ref_o(spd));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Ceiling well above the roughly 310 cycles the run needs
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			final_report();
		end
	end
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, exp);
	endtask
	task automatic t_regs();
		rd(`FSC_ADDR_TORQUE, 32'h0000_0320);
		rd(`FSC_ADDR_MAXTRQ, 32'h0000_012C);
		rd(`FSC_ADDR_STATUS, 32'h0000_0008);
		wr(`FSC_ADDR_CTRL, 32'h0000_0017);
		rd(`FSC_ADDR_CTRL, 32'h0000_0010);
		rd(8'h40, 32'h0000_0000);
		wr(`FSC_ADDR_TORQUE, 32'h0000_0384);
		rd(`FSC_ADDR_TORQUE, 32'h0000_0320);
		wr(`FSC_ADDR_DECEL, 32'h0000_3000);
		rd(`FSC_ADDR_DECEL, 32'h0000_2EE0);
		wr(`FSC_ADDR_DECEL, 32'h0000_0000);
		open_cmd <= 1'b1;
		wait_n(8);
		chk(ind, 1'b0);
		open_cmd <= 1'b0;
		wait_n(8);
		$display("test regs done");
	endtask
	task automatic t_stop(input logic [2:0] m, input logic [9:0] t, input logic tq,
			input logic [9:0] e_trq, input logic e_dec, input logic e_brk);
		wr(`FSC_ADDR_TORQUE, {22'h00_0000, t});
		wr(`FSC_ADDR_CTRL, {19'h0_0000, 1'b1, 4'h1, 2'h0, tq, 1'b1, 1'b0, m});
		open_cmd <= (m != 3'h0);
		wire_break <= (m == 3'h0);
		wait_n(8);
		chk(ind, 1'b1);
		chk(decel, e_dec);
		chk(trq, e_trq);
		chk(spd, 16'h0000);
		stopped <= 1'b1;
		wait_n(8);
		chk(decel, 1'b0);
		chk(brake, e_brk);
		open_cmd <= 1'b0;
		wire_break <= 1'b0;
		wait_n(8);
		chk(ind, 1'b1);
		servo_cmd <= 1'b0;
		wait_n(8);
		chk(blocked, 1'b1);
		servo_cmd <= 1'b1;
		stopped <= 1'b0;
		wait_n(8);
		chk(ind, 1'b0);
		$display("test stop method %0d done", m);
	endtask
	initial begin
		wait_n(8);
		sys_rst_i <= 1'b0;
		t_regs();
		t_stop(3'h0, 10'h320, 1'b0, 10'h12C, 1'b0, 1'b1);
		t_stop(3'h1, 10'h320, 1'b0, 10'h12C, 1'b1, 1'b1);
		t_stop(3'h2, 10'h032, 1'b0, 10'h032, 1'b1, 1'b0);
		t_stop(3'h3, 10'h320, 1'b0, 10'h12C, 1'b0, 1'b1);
		t_stop(3'h4, 10'h320, 1'b0, 10'h12C, 1'b0, 1'b0);
		t_stop(3'h1, 10'h320, 1'b1, 10'h12C, 1'b0, 1'b1);
		final_report();
	end
endmodule
`default_nettype wire
